// file: cse_core.sv
// Functional notes
// - Six-bit stack pointer, wraps within 64 bytes
// - Reset and stack reset load pointer 00FF
// - Decrement after push, increment before pull
// - Stack address is 0000000011 plus pointer
// - Call uses two bytes, interrupt five
// - Accumulator and index survive reset
// - Indexed address: none, 8-bit, 16-bit offset
// - Program counter increments, jumps load target
// - Five flags, upper three read one
// - Half carry from bit 3 on adds
// - Mask set after stacking, before vector
// - Masked requests stay pending until unmasked
// - Return from interrupt restores all registers
// - Reset sets mask; clear-mask or wait clear
// - Negative flag copies result bit 7
// - Zero flag set on zero result
// - Carry from arithmetic, shifts, bit tests
// - Interrupts wait for instruction completion
// - Take interrupt only unmasked and enabled
// - Highest hardware vector served first; a hardware request beats a software interrupt in the same cycle
// - Four vector slots FFE FFC FFA FF8
// - Software interrupt ignores the mask
// - Reset sets mask and loads reset vector
//
// Strobed register access and the placing of the registers were left to the implementer.
`include "cse_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cse_core #(
	parameter int ADDR_W = `CSE_ADDR_W
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic int_reset,
	// Instruction sequencer
	input wire logic cmd_valid,
	input wire cse_pkg::cse_cmd_t cmd,
	input wire logic [7:0] cmd_data,
	input wire logic [15:0] cmd_addr,
	input wire logic instr_done,
	output logic cmd_ready,
	// Indexed addressing
	input wire cse_pkg::cse_idx_mode_t idx_mode,
	input wire logic [15:0] idx_offset,
	output logic [15:0] eff_addr,
	// Interrupt sources
	input wire logic ext_irq_flag,
	input wire logic ext_irq_en,
	input wire logic tmr_irq_flag,
	input wire logic tmr_irq_en,
	output logic ext_vec_ack,
	output logic tmr_vec_ack,
	// Memory bus for stacking and vector fetch
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic mem_we,
	output logic mem_re,
	input wire logic [7:0] mem_rdata,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata
);
	import cse_pkg::*;

	// Refuse address widths that cannot hold the vector table
	generate
		if (ADDR_W < 12 || ADDR_W > 16) begin : g_bad_width
			$error("cse_core: ADDR_W must be 12 to 16");
		end
	endgenerate

	cse_state_t state_q; // Sequencer state
	cse_kind_t kind_q; // Sequence in progress
	logic [2:0] cnt_q; // Byte index within sequence
	logic [15:0] vec_q; // Vector slot being fetched
	logic [7:0] hold_q; // High byte awaiting its partner
	logic [15:0] tgt_q; // Call target held during push
	logic [5:0] sp_q; // Stack pointer, writable bits only
	logic [ADDR_W-1:0] pc_q; // Program counter
	logic [7:0] acc_q; // Accumulator, no reset
	logic [7:0] idx_q; // Index register, no reset
	logic h_q, n_q, z_q, c_q; // Result flags, no reset
	logic imask_q; // Interrupt mask
	logic [15:0] ea_q; // Effective address
	logic ext_ack_q, tmr_ack_q; // Vector fetch acknowledges

	logic [15:0] pc16; // Program counter widened
	logic [7:0] condition_flags_reg; // Full condition byte
	logic [5:0] sp_inc; // Pointer plus one
	logic ext_pend, tmr_pend, hw_pend; // Enabled requests
	logic take_irq; // Interrupt taken at boundary
	logic cmd_go; // Command accepted
	logic run; // Idle between sequences
	logic [2:0] pull_sel; // Frame slot of pulled byte
	logic last_push, last_pull; // Final byte of a frame
	logic [7:0] push_byte; // Byte written to stack
	logic [15:0] pull_pc; // Pulled or fetched address

	// ALU results
	logic [7:0] alu_res;
	logic alu_c, alu_h, alu_wr_a, alu_upd_c, alu_upd_h, alu_upd_nz;
	logic [8:0] sum9;
	logic [4:0] half5;

	assign pc16 = 16'(pc_q);
	assign condition_flags_reg = {`CSE_CCR_ONES, h_q, imask_q, n_q, z_q, c_q};
	assign sp_inc = sp_q + 6'h01;
	assign ext_pend = ext_irq_flag && ext_irq_en;
	assign tmr_pend = tmr_irq_flag && tmr_irq_en;
	assign hw_pend = ext_pend || tmr_pend;
	assign run = (state_q == ST_RUN);
	// A request only counts at an instruction boundary while unmasked
	assign take_irq = run && instr_done && !imask_q && hw_pend;
	assign cmd_ready = run && !take_irq && !int_reset;
	assign cmd_go = cmd_valid && cmd_ready;
	// Return from subroutine reuses the last two slots of the frame
	assign pull_sel = (kind_q == K_RTS) ? cnt_q + 3'h3 : cnt_q;
	assign last_push = (kind_q == K_JSR) ? (cnt_q == `CSE_CALL_BYTES - 3'h1)
		: (cnt_q == `CSE_INT_BYTES - 3'h1);
	assign last_pull = (kind_q == K_RTS) ? (cnt_q == `CSE_CALL_BYTES - 3'h1)
		: (cnt_q == `CSE_INT_BYTES - 3'h1);
	assign pull_pc = {hold_q, mem_rdata};
	assign ext_vec_ack = ext_ack_q;
	assign tmr_vec_ack = tmr_ack_q;
	assign eff_addr = ea_q;

	// Byte pushed in each slot of the frame
	always_comb begin
		case (cnt_q)
			3'h0: push_byte = pc16[7:0];
			3'h1: push_byte = pc16[15:8];
			3'h2: push_byte = idx_q;
			3'h3: push_byte = acc_q;
			default: push_byte = condition_flags_reg;
		endcase
	end

	// Memory bus drive from sequencer state
	always_comb begin
		mem_addr = 16'h0000;
		mem_wdata = 8'h00;
		mem_we = 1'b0;
		mem_re = 1'b0;
		case (state_q)
			ST_PUSH: begin
				mem_addr = {`CSE_STACK_PAGE, sp_q};
				mem_wdata = push_byte;
				mem_we = 1'b1;
			end
			ST_PULL_RD: begin
				mem_addr = {`CSE_STACK_PAGE, sp_inc};
				mem_re = 1'b1;
			end
			ST_VEC_RD: begin
				mem_addr = vec_q + 16'(cnt_q);
				mem_re = 1'b1;
			end
			default: begin
				mem_addr = 16'h0000;
			end
		endcase
	end

	// Accumulator operations and their flag effects
	always_comb begin
		alu_res = acc_q;
		alu_c = c_q;
		alu_h = h_q;
		alu_wr_a = 1'b0;
		alu_upd_c = 1'b0;
		alu_upd_h = 1'b0;
		alu_upd_nz = 1'b0;
		sum9 = 9'h000;
		half5 = 5'h00;
		case (cmd)
			CMD_ADD, CMD_ADC: begin
				// Carry in only for add with carry
				sum9 = {1'b0, acc_q} + {1'b0, cmd_data} + {8'h00, (cmd == CMD_ADC) && c_q};
				half5 = {1'b0, acc_q[3:0]} + {1'b0, cmd_data[3:0]} + {4'h0, (cmd == CMD_ADC) && c_q};
				alu_res = sum9[7:0];
				alu_c = sum9[8];
				alu_h = half5[4];
				alu_wr_a = 1'b1;
				alu_upd_c = 1'b1;
				alu_upd_h = 1'b1;
				alu_upd_nz = 1'b1;
			end
			CMD_SUB: begin
				// Borrow shows as carry
				sum9 = {1'b0, acc_q} - {1'b0, cmd_data};
				alu_res = sum9[7:0];
				alu_c = sum9[8];
				alu_wr_a = 1'b1;
				alu_upd_c = 1'b1;
				alu_upd_nz = 1'b1;
			end
			CMD_AND: begin
				alu_res = acc_q & cmd_data;
				alu_wr_a = 1'b1;
				alu_upd_nz = 1'b1;
			end
			CMD_ORA: begin
				alu_res = acc_q | cmd_data;
				alu_wr_a = 1'b1;
				alu_upd_nz = 1'b1;
			end
			CMD_EOR: begin
				alu_res = acc_q ^ cmd_data;
				alu_wr_a = 1'b1;
				alu_upd_nz = 1'b1;
			end
			CMD_LDA: begin
				alu_res = cmd_data;
				alu_wr_a = 1'b1;
				alu_upd_nz = 1'b1;
			end
			CMD_LDX: begin
				// Result goes to index; flags follow the loaded byte
				alu_res = cmd_data;
				alu_upd_nz = 1'b1;
			end
			CMD_INC, CMD_DEC: begin
				// Carry is left alone
				alu_res = (cmd == CMD_INC) ? acc_q + 8'h01 : acc_q - 8'h01;
				alu_wr_a = 1'b1;
				alu_upd_nz = 1'b1;
			end
			CMD_ASL, CMD_ROL: begin
				alu_res = {acc_q[6:0], (cmd == CMD_ROL) && c_q};
				alu_c = acc_q[7];
				alu_wr_a = 1'b1;
				alu_upd_c = 1'b1;
				alu_upd_nz = 1'b1;
			end
			CMD_LSR, CMD_ROR: begin
				alu_res = {(cmd == CMD_ROR) && c_q, acc_q[7:1]};
				alu_c = acc_q[0];
				alu_wr_a = 1'b1;
				alu_upd_c = 1'b1;
				alu_upd_nz = 1'b1;
			end
			CMD_BTST: begin
				// Tested bit of the operand lands in carry
				alu_c = cmd_data[cmd_addr[2:0]];
				alu_upd_c = 1'b1;
			end
			default: begin
				alu_res = acc_q;
			end
		endcase
	end

	// Sequencer: interrupt entry, calls, returns, vector fetch
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_VEC_RD;
			kind_q <= K_RESET;
			cnt_q <= 3'h0;
			vec_q <= `CSE_VEC_RESET;
		end else if (int_reset) begin
			// Internal reset abandons any sequence
			state_q <= ST_VEC_RD;
			kind_q <= K_RESET;
			cnt_q <= 3'h0;
			vec_q <= `CSE_VEC_RESET;
		end else begin
			case (state_q)
				ST_RUN: begin
					cnt_q <= 3'h0;
					if (take_irq) begin
						state_q <= ST_PUSH;
						kind_q <= K_INT;
					end else if (cmd_go && cmd == CMD_SWI) begin
						state_q <= ST_PUSH;
						kind_q <= K_INT;
						vec_q <= `CSE_VEC_SWI;
					end else if (cmd_go && cmd == CMD_JSR) begin
						state_q <= ST_PUSH;
						kind_q <= K_JSR;
					end else if (cmd_go && cmd == CMD_RTI) begin
						state_q <= ST_PULL_RD;
						kind_q <= K_RTI;
					end else if (cmd_go && cmd == CMD_RTS) begin
						state_q <= ST_PULL_RD;
						kind_q <= K_RTS;
					end
				end
				ST_PUSH: begin
					if (!last_push) begin
						cnt_q <= cnt_q + 3'h1;
					end else if (kind_q == K_JSR) begin
						state_q <= ST_RUN;
					end else begin
						// Source chosen only after stacking, highest slot first
						state_q <= ST_VEC_RD;
						cnt_q <= 3'h0;
						if (vec_q != `CSE_VEC_SWI) begin
							vec_q <= ext_pend ? `CSE_VEC_EXT : `CSE_VEC_TMR;
						end
					end
				end
				ST_PULL_RD: begin
					state_q <= ST_PULL_CAP;
				end
				ST_PULL_CAP: begin
					if (last_pull) begin
						state_q <= ST_RUN;
					end else begin
						state_q <= ST_PULL_RD;
						cnt_q <= cnt_q + 3'h1;
					end
				end
				ST_VEC_RD: begin
					state_q <= ST_VEC_CAP;
				end
				ST_VEC_CAP: begin
					if (cnt_q == `CSE_LAST_VEC) begin
						state_q <= ST_RUN;
						vec_q <= 16'h0000;
					end else begin
						state_q <= ST_VEC_RD;
						cnt_q <= cnt_q + 3'h1;
					end
				end
				default: begin
					state_q <= ST_RUN;
				end
			endcase
		end
	end

	// Call target capture
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tgt_q <= 16'h0000;
		end else if (cmd_go && cmd == CMD_JSR) begin
			tgt_q <= cmd_addr;
		end
	end

	// High byte holding for two-byte reads
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hold_q <= 8'h00;
		end else if (state_q == ST_VEC_CAP || state_q == ST_PULL_CAP) begin
			hold_q <= mem_rdata;
		end
	end

	// Stack pointer
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sp_q <= `CSE_SP_TOP;
		end else if (int_reset || (cmd_go && cmd == CMD_RSP)) begin
			sp_q <= `CSE_SP_TOP;
		end else if (state_q == ST_PUSH) begin
			// Wraps from the bottom of the page back to the top
			sp_q <= sp_q - 6'h01;
		end else if (state_q == ST_PULL_RD) begin
			sp_q <= sp_inc;
		end
	end

	// Program counter
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pc_q <= '0;
		end else if (state_q == ST_VEC_CAP && cnt_q == `CSE_LAST_VEC) begin
			pc_q <= pull_pc[ADDR_W-1:0];
		end else if (state_q == ST_PULL_CAP && pull_sel == 3'h4) begin
			pc_q <= pull_pc[ADDR_W-1:0];
		end else if (state_q == ST_PUSH && kind_q == K_JSR && last_push) begin
			pc_q <= tgt_q[ADDR_W-1:0];
		end else if (cmd_go && cmd == CMD_FETCH) begin
			pc_q <= pc_q + 1'b1;
		end else if (cmd_go && cmd == CMD_JMP) begin
			pc_q <= cmd_addr[ADDR_W-1:0];
		end else if (cmd_go && cmd == CMD_BRA) begin
			// Relative branch with signed byte offset
			pc_q <= pc_q + ADDR_W'({{8{cmd_data[7]}}, cmd_data});
		end
	end

	// Accumulator and index, deliberately without reset
	always_ff @(posedge ref_clk) begin
		if (state_q == ST_PULL_CAP && pull_sel == 3'h1) begin
			acc_q <= mem_rdata;
		end else if (state_q == ST_PULL_CAP && pull_sel == 3'h2) begin
			idx_q <= mem_rdata;
		end else if (reg_wr && reg_addr == `CSE_REG_ACC) begin
			acc_q <= reg_wdata;
		end else if (reg_wr && reg_addr == `CSE_REG_IDX) begin
			idx_q <= reg_wdata;
		end else if (cmd_go && alu_wr_a) begin
			acc_q <= alu_res;
		end else if (cmd_go && cmd == CMD_LDX) begin
			idx_q <= alu_res;
		end
	end

	// Result flags, untouched by reset
	always_ff @(posedge ref_clk) begin
		if (state_q == ST_PULL_CAP && pull_sel == 3'h0) begin
			h_q <= mem_rdata[`CSE_CCR_H];
			n_q <= mem_rdata[`CSE_CCR_N];
			z_q <= mem_rdata[`CSE_CCR_Z];
			c_q <= mem_rdata[`CSE_CCR_C];
		end else if (cmd_go) begin
			if (alu_upd_h) begin
				h_q <= alu_h;
			end
			if (alu_upd_c) begin
				c_q <= alu_c;
			end
			if (alu_upd_nz) begin
				n_q <= alu_res[7];
				z_q <= (alu_res == 8'h00);
			end
		end
	end

	// Interrupt mask
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			imask_q <= 1'b1;
		end else if (int_reset) begin
			imask_q <= 1'b1;
		end else if (state_q == ST_PUSH && kind_q == K_INT && last_push) begin
			imask_q <= 1'b1;
		end else if (state_q == ST_PULL_CAP && pull_sel == 3'h0) begin
			imask_q <= mem_rdata[`CSE_CCR_I];
		end else if (cmd_go && (cmd == CMD_CLI || cmd == CMD_WAIT)) begin
			imask_q <= 1'b0;
		end else if (cmd_go && cmd == CMD_SEI) begin
			imask_q <= 1'b1;
		end
	end

	// Vector fetch acknowledges, one cycle on the low byte
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ext_ack_q <= 1'b0;
			tmr_ack_q <= 1'b0;
		end else begin
			ext_ack_q <= (state_q == ST_VEC_CAP) && (cnt_q == `CSE_LAST_VEC) && (vec_q == `CSE_VEC_EXT);
			tmr_ack_q <= (state_q == ST_VEC_CAP) && (cnt_q == `CSE_LAST_VEC) && (vec_q == `CSE_VEC_TMR);
		end
	end

	// Effective address for indexed operands
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ea_q <= 16'h0000;
		end else begin
			case (idx_mode)
				IDX_NONE: ea_q <= {8'h00, idx_q};
				IDX_OFF8: ea_q <= {8'h00, idx_q} + {8'h00, idx_offset[7:0]};
				IDX_OFF16: ea_q <= {8'h00, idx_q} + idx_offset;
				default: ea_q <= {8'h00, idx_q};
			endcase
		end
	end

	// Register read port, data one cycle after the strobe
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`CSE_REG_ACC: reg_rdata <= acc_q;
				`CSE_REG_IDX: reg_rdata <= idx_q;
				`CSE_REG_SP: reg_rdata <= {2'b11, sp_q};
				`CSE_REG_CCR: reg_rdata <= condition_flags_reg;
				`CSE_REG_PC_HI: reg_rdata <= pc16[15:8];
				`CSE_REG_PC_LO: reg_rdata <= pc16[7:0];
				`CSE_REG_STATUS: reg_rdata <= {4'h0, !run, ext_pend, tmr_pend, imask_q};
				`CSE_REG_EA_HI: reg_rdata <= ea_q[15:8];
				`CSE_REG_EA_LO: reg_rdata <= ea_q[7:0];
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule : cse_core
`default_nettype wire

// file: cse_params.svh
`ifndef CSE_PARAMS_SVH
`define CSE_PARAMS_SVH

// Register port offsets
`define CSE_REG_ACC 4'h0
`define CSE_REG_IDX 4'h1
`define CSE_REG_SP 4'h2
`define CSE_REG_CCR 4'h3
`define CSE_REG_PC_HI 4'h4
`define CSE_REG_PC_LO 4'h5
`define CSE_REG_STATUS 4'h6
`define CSE_REG_EA_HI 4'h7
`define CSE_REG_EA_LO 4'h8

// Condition flag bit positions
`define CSE_CCR_C 0
`define CSE_CCR_Z 1
`define CSE_CCR_N 2
`define CSE_CCR_I 3
`define CSE_CCR_H 4
`define CSE_CCR_ONES 3'h7

// Stack page and pointer
`define CSE_STACK_PAGE 10'h003
`define CSE_SP_TOP 6'h3f

// Vector slots (high byte first, low byte at slot plus one)
`define CSE_VEC_RESET 16'h0ffe
`define CSE_VEC_SWI 16'h0ffc
`define CSE_VEC_EXT 16'h0ffa
`define CSE_VEC_TMR 16'h0ff8

// Byte counts of stack frames, and index of the last vector byte
`define CSE_INT_BYTES 3'h5
`define CSE_CALL_BYTES 3'h2
`define CSE_LAST_VEC 3'h1

// Implemented program address width
`define CSE_ADDR_W 12

`endif

// file: cse_pkg.sv
`default_nettype none
package cse_pkg;

	// Commands from the instruction sequencer
	typedef enum logic [4:0] {
		CMD_NOP, CMD_FETCH, CMD_JMP, CMD_BRA, CMD_ADD, CMD_ADC, CMD_SUB, CMD_AND,
		CMD_ORA, CMD_EOR, CMD_LDA, CMD_LDX, CMD_INC, CMD_DEC, CMD_ASL, CMD_LSR,
		CMD_ROL, CMD_ROR, CMD_BTST, CMD_RSP, CMD_CLI, CMD_SEI, CMD_WAIT, CMD_SWI,
		CMD_RTI, CMD_JSR, CMD_RTS
	} cse_cmd_t;

	// Indexed address forms
	typedef enum logic [1:0] {IDX_NONE, IDX_OFF8, IDX_OFF16} cse_idx_mode_t;

	// Sequencer states
	typedef enum logic [2:0] {ST_RUN, ST_PUSH, ST_PULL_RD, ST_PULL_CAP, ST_VEC_RD, ST_VEC_CAP} cse_state_t;

	// Kind of stack or vector sequence in progress
	typedef enum logic [2:0] {K_INT, K_JSR, K_RTI, K_RTS, K_RESET} cse_kind_t;

endpackage : cse_pkg
`default_nettype wire

// file: cse_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cse_mem_model #(
	parameter logic [15:0] RST_VEC = 16'h0123,
	parameter logic [15:0] SWI_VEC = 16'h0456,
	parameter logic [15:0] EXT_VEC = 16'h0789,
	parameter logic [15:0] TMR_VEC = 16'h0abc
) (
	// Clock
	input wire logic ref_clk,
	// Memory bus
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_we,
	input wire logic mem_re,
	output logic [7:0] mem_rdata
);
	// Byte store, vector slots high byte first
	logic [7:0] mem [0:65535];
	initial begin
		mem_rdata = 8'h00;
		{mem[16'h0ffe], mem[16'h0fff]} = RST_VEC;
		{mem[16'h0ffc], mem[16'h0ffd]} = SWI_VEC;
		{mem[16'h0ffa], mem[16'h0ffb]} = EXT_VEC;
		{mem[16'h0ff8], mem[16'h0ff9]} = TMR_VEC;
	end
	// Data stands only in the cycle after a read, else it toggles
	always @(posedge ref_clk) begin
		if (mem_we) begin
			mem[mem_addr] <= mem_wdata;
		end
		if (mem_re) begin
			mem_rdata <= mem[mem_addr];
		end else begin
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule : cse_mem_model
`default_nettype wire

// file: cse_core_chk.sv
`include "cse_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cse_core_chk
	import cse_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Sequencer
	input wire logic cmd_valid,
	input wire cse_pkg::cse_cmd_t cmd,
	input wire logic cmd_ready,
	// Indexed addressing
	input wire cse_pkg::cse_idx_mode_t idx_mode,
	input wire logic [15:0] eff_addr,
	// Memory bus
	input wire logic [15:0] mem_addr,
	input wire logic mem_we,
	input wire logic mem_re,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	logic [2:0] run_q; // Length of the current push run
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// Count consecutive push cycles
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			run_q <= 3'h0;
		end else if (mem_we) begin
			run_q <= run_q + 3'h1;
		end else begin
			run_q <= 3'h0;
		end
	end
	property p_stack_page;
		mem_we |-> mem_addr[15:6] == `CSE_STACK_PAGE;
	endproperty
	a_stack_page: assert property (p_stack_page) else $error("push outside stack page");
	property p_push_dec;
		mem_we && $past(mem_we) |-> mem_addr[5:0] == 6'($past(mem_addr) - 16'h0001);
	endproperty
	a_push_dec: assert property (p_push_dec) else $error("push pointer not decremented");
	property p_pull_inc;
		mem_re && $past(mem_re, 2) && mem_addr[15:6] == `CSE_STACK_PAGE
			|-> mem_addr[5:0] == 6'($past(mem_addr, 2) + 16'h0001);
	endproperty
	a_pull_inc: assert property (p_pull_inc) else $error("pull pointer not incremented");
	property p_int_frame;
		$fell(mem_we) && mem_re |-> run_q == 3'h5 && mem_addr inside {`CSE_VEC_SWI, `CSE_VEC_EXT, `CSE_VEC_TMR};
	endproperty
	a_int_frame: assert property (p_int_frame) else $error("bad interrupt frame");
	property p_call_frame;
		$fell(mem_we) && !mem_re |-> run_q == 3'h2;
	endproperty
	a_call_frame: assert property (p_call_frame) else $error("bad call frame");
	property p_swi_entry;
		cmd_valid && cmd_ready && cmd == CMD_SWI |-> ##1 mem_we [*5] ##1 (mem_re && mem_addr == `CSE_VEC_SWI);
	endproperty
	a_swi_entry: assert property (p_swi_entry) else $error("software entry wrong");
	property p_rti_pulls;
		cmd_valid && cmd_ready && cmd == CMD_RTI
			|-> ##1 mem_re ##2 mem_re ##2 mem_re ##2 mem_re ##2 mem_re ##2 cmd_ready;
	endproperty
	a_rti_pulls: assert property (p_rti_pulls) else $error("return pulls wrong");
	property p_reset_vec;
		$fell(rst) |-> (mem_re && mem_addr == `CSE_VEC_RESET) ##[1:3] (mem_re && mem_addr == 16'h0fff);
	endproperty
	a_reset_vec: assert property (p_reset_vec) else $error("reset vector not fetched");
	property p_ccr_ones;
		$past(reg_rd) && $past(reg_addr) == `CSE_REG_CCR |-> reg_rdata[7:5] == `CSE_CCR_ONES;
	endproperty
	a_ccr_ones: assert property (p_ccr_ones) else $error("flag upper bits not ones");
	property p_idx_none;
		$past(idx_mode) == IDX_NONE |-> eff_addr[15:8] == 8'h00;
	endproperty
	a_idx_none: assert property (p_idx_none) else $error("plain indexed high byte not zero");
	// Main scenarios reached
	c_swi: cover property (cmd_valid && cmd_ready && cmd == CMD_SWI);
	c_ext: cover property (mem_re && mem_addr == `CSE_VEC_EXT);
	c_tmr: cover property (mem_re && mem_addr == `CSE_VEC_TMR);
endmodule : cse_core_chk
bind cse_core cse_core_chk chk_u (
	.ref_clk(ref_clk),
	.rst(rst),
	.cmd_valid(cmd_valid),
	.cmd(cmd),
	.cmd_ready(cmd_ready),
	.idx_mode(idx_mode),
	.eff_addr(eff_addr),
	.mem_addr(mem_addr),
	.mem_we(mem_we),
	.mem_re(mem_re),
	.reg_addr(reg_addr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata)
);
`default_nettype wire

// file: test_cse_core.sv
`include "cse_params.svh"
`timescale 1ns/1ps
`default_nettype none
module test_cse_core;
	import cse_pkg::*;
	// Vector targets held by the memory model
	localparam logic [15:0] V_RST = 16'h0123;
	localparam logic [15:0] V_SWI = 16'h0456;
	localparam logic [15:0] V_EXT = 16'h0789;
	localparam logic [15:0] V_TMR = 16'h0abc;
	// Design connections
	logic ref_clk, rst, int_reset, cmd_valid, instr_done, cmd_ready;
	cse_cmd_t cmd;
	logic [7:0] cmd_data, mem_wdata, mem_rdata, reg_wdata, reg_rdata, rdv;
	logic [15:0] cmd_addr, idx_offset, eff_addr, mem_addr;
	cse_idx_mode_t idx_mode;
	logic ext_irq_flag, ext_irq_en, tmr_irq_flag, tmr_irq_en, ext_vec_ack, tmr_vec_ack;
	logic mem_we, mem_re, reg_wr, reg_rd;
	logic [3:0] reg_addr;
	// Tallies
	int n_fail = 0;
	int checks_done = 0;
	int n_ext = 0;
	int n_tmr = 0;
	cse_core dut_u (.ref_clk(ref_clk), .rst(rst), .int_reset(int_reset), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_data(cmd_data), .cmd_addr(cmd_addr), .instr_done(instr_done), .cmd_ready(cmd_ready),
		.idx_mode(idx_mode), .idx_offset(idx_offset), .eff_addr(eff_addr), .ext_irq_flag(ext_irq_flag),
		.ext_irq_en(ext_irq_en), .tmr_irq_flag(tmr_irq_flag), .tmr_irq_en(tmr_irq_en),
		.ext_vec_ack(ext_vec_ack), .tmr_vec_ack(tmr_vec_ack), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	cse_mem_model #(.RST_VEC(V_RST), .SWI_VEC(V_SWI), .EXT_VEC(V_EXT), .TMR_VEC(V_TMR)) mem_u (
		.ref_clk(ref_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
		.mem_rdata(mem_rdata));
	// 25 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// Count vector acknowledge pulses
	always @(posedge ref_clk) begin
		n_ext <= n_ext + int'(ext_vec_ack === 1'b1);
		n_tmr <= n_tmr + int'(tmr_vec_ack === 1'b1);
	end
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test
	// Bounded wait for the sequencer to go idle
	task automatic wait_ready();
		int k = 0;
		do begin
			@(posedge ref_clk);
			#1;
			k++;
		end while (cmd_ready !== 1'b1 && k < 40);
		if (cmd_ready !== 1'b1) begin
			chk("cmd_ready", 16'h0001, 16'(cmd_ready));
			stop_test();
		end
	endtask : wait_ready
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data stands in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 rdv = reg_rdata;
	endtask : rd
	task automatic rchk(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
		rd(a);
		chk("reg_rdata", 16'(e), 16'(rdv & m));
	endtask : rchk
	task automatic rpc(input logic [15:0] e);
		rchk(`CSE_REG_PC_HI, e[15:8], 8'hff);
		rchk(`CSE_REG_PC_LO, e[7:0], 8'hff);
	endtask : rpc
	task automatic go(input cse_cmd_t c, input logic [7:0] d, input logic [15:0] a);
		wait_ready();
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd <= c;
		cmd_data <= d;
		cmd_addr <= a;
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		wait_ready();
	endtask : go
	task automatic done_pulse();
		@(posedge ref_clk);
		instr_done <= 1'b1;
		@(posedge ref_clk);
		instr_done <= 1'b0;
		wait_ready();
	endtask : done_pulse
	// Reset state, then contents kept over an internal reset
	task automatic t_reset();
		wait_ready();
		rpc(V_RST);
		rchk(`CSE_REG_SP, 8'hff, 8'hff);
		rchk(`CSE_REG_CCR, 8'he8, 8'he8);
		rchk(4'hf, 8'h00, 8'hff);
		wr(`CSE_REG_ACC, 8'h5a);
		wr(`CSE_REG_IDX, 8'h10);
		@(posedge ref_clk);
		int_reset <= 1'b1;
		@(posedge ref_clk);
		int_reset <= 1'b0;
		wait_ready();
		rpc(V_RST);
		rchk(`CSE_REG_ACC, 8'h5a, 8'hff);
		rchk(`CSE_REG_IDX, 8'h10, 8'hff);
	endtask : t_reset
	// Flag results of accumulator, bit test and mask commands (H I N Z C)
	task automatic t_alu();
		cse_cmd_t c[13] = '{CMD_LDA, CMD_ADD, CMD_ADD, CMD_INC, CMD_LDA, CMD_LDA, CMD_SUB, CMD_BTST, CMD_ASL,
			CMD_DEC, CMD_ADC, CMD_WAIT, CMD_SEI};
		logic [7:0] d[13] = '{8'h08, 8'h08, 8'hf0, 8'h00, 8'h80, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h02,
			8'h00, 8'h00};
		logic [7:0] f[13] = '{8'h08, 8'h18, 8'h0b, 8'h09, 8'h0d, 8'h0b, 8'h0d, 8'h0c, 8'h0d, 8'h0d, 8'h1b,
			8'h13, 8'h1b};
		for (int i = 0; i < 13; i++) begin
			go(c[i], d[i], 16'h0000);
			if (i > 0) rchk(`CSE_REG_CCR, f[i], 8'h1f);
		end
	endtask : t_alu
	// Three indexed forms, index holds 10
	task automatic t_idx();
		cse_idx_mode_t m[3] = '{IDX_NONE, IDX_OFF8, IDX_OFF16};
		logic [15:0] o[3] = '{16'hffff, 16'h00f0, 16'h1234};
		logic [15:0] e[3] = '{16'h0010, 16'h0100, 16'h1244};
		for (int i = 0; i < 3; i++) begin
			@(posedge ref_clk);
			idx_mode <= m[i];
			idx_offset <= o[i];
			repeat (2) @(posedge ref_clk);
			#1 chk("eff_addr", e[i], eff_addr);
		end
	endtask : t_idx
	task automatic t_pc();
		go(CMD_JMP, 8'h00, 16'h0200);
		go(CMD_FETCH, 8'h00, 16'h0000);
		rpc(16'h0201);
		go(CMD_BRA, 8'hfe, 16'h0000);
		rpc(16'h01ff);
		go(CMD_JMP, 8'h00, 16'hf201);
		rpc(16'h0201);
	endtask : t_pc
	// Software entry while masked, frame contents, return
	task automatic t_swi();
		logic [7:0] st[5] = '{8'h01, 8'h02, 8'h10, 8'h5a, 8'hfb};
		wr(`CSE_REG_ACC, 8'h5a);
		go(CMD_SWI, 8'h00, 16'h0000);
		rpc(V_SWI);
		rchk(`CSE_REG_SP, 8'hfa, 8'hff);
		for (int i = 0; i < 5; i++) chk("stack", 16'(st[i]), 16'(mem_u.mem[255 - i]));
		go(CMD_RTI, 8'h00, 16'h0000);
		rpc(16'h0201);
		rchk(`CSE_REG_SP, 8'hff, 8'hff);
		rchk(`CSE_REG_CCR, 8'hfb, 8'hff);
	endtask : t_swi
	// Masked, disabled, then both pending
	task automatic t_irq();
		@(posedge ref_clk);
		ext_irq_flag <= 1'b1;
		tmr_irq_flag <= 1'b1;
		done_pulse();
		rpc(16'h0201);
		go(CMD_CLI, 8'h00, 16'h0000);
		done_pulse();
		rpc(16'h0201);
		@(posedge ref_clk);
		ext_irq_en <= 1'b1;
		tmr_irq_en <= 1'b1;
		done_pulse();
		rpc(V_EXT);
		rchk(`CSE_REG_CCR, 8'h08, 8'h08);
		chk("ext_ack", 16'h0001, 16'(n_ext));
		@(posedge ref_clk);
		ext_irq_flag <= 1'b0;
		go(CMD_RTI, 8'h00, 16'h0000);
		rchk(`CSE_REG_CCR, 8'h00, 8'h08);
		done_pulse();
		rpc(V_TMR);
		chk("tmr_ack", 16'h0001, 16'(n_tmr));
		@(posedge ref_clk);
		tmr_irq_flag <= 1'b0;
		go(CMD_RSP, 8'h00, 16'h0000);
		rchk(`CSE_REG_SP, 8'hff, 8'hff);
	endtask : t_irq
	// 32 calls fill the page and wrap, then one return
	task automatic t_wrap();
		for (int i = 0; i < 32; i++) go(CMD_JSR, 8'h00, 16'h0300);
		rchk(`CSE_REG_SP, 8'hff, 8'hff);
		chk("wrap_pch", 16'h0003, 16'(mem_u.mem[16'h00c0]));
		go(CMD_RTS, 8'h00, 16'h0000);
		rpc(16'h0300);
		rchk(`CSE_REG_SP, 8'hc1, 8'hff);
	endtask : t_wrap
	initial begin
		rst = 1'b1;
		{int_reset, cmd_valid, instr_done, reg_wr, reg_rd} = 5'h00;
		{ext_irq_flag, ext_irq_en, tmr_irq_flag, tmr_irq_en} = 4'h0;
		cmd = CMD_NOP;
		{cmd_data, cmd_addr, idx_offset, reg_addr, reg_wdata} = 52'h0;
		idx_mode = IDX_NONE;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_alu();
		t_idx();
		t_pc();
		t_swi();
		t_irq();
		t_wrap();
		stop_test();
	end
endmodule : test_cse_core
`default_nettype wire
